// [hw/med_map.svh]
// register offsets, reset values and timing counts of the motion event block
`ifndef MED_MAP_SVH
`define MED_MAP_SVH
`define MED_A_ID        6'h00
`define MED_A_TAP_LVL   6'h1d
`define MED_A_TRIM_X    6'h1e
`define MED_A_TRIM_Y    6'h1f
`define MED_A_TRIM_Z    6'h20
`define MED_A_TAP_WIDTH 6'h21
`define MED_A_TAP_GAP   6'h22
`define MED_A_TAP_SPAN  6'h23
`define MED_A_MOT_LVL   6'h24
`define MED_A_STILL_LVL 6'h25
`define MED_A_STILL_TIM 6'h26
`define MED_A_COUPLING  6'h27
`define MED_A_FALL_LVL  6'h28
`define MED_A_FALL_TIM  6'h29
`define MED_A_TAP_AXES  6'h2a
`define MED_A_ORIGIN    6'h2b
`define MED_A_SPEED     6'h2c
`define MED_SPEED_RST   5'h0a
`define MED_ID_VALUE    8'h5a
`define MED_B_LOWPWR    4
`define MED_B_INHIBIT   3
`define MED_B_ACT_AC    7
`define MED_B_INACT_AC  3
`define MED_CLK_NS      20
`define MED_TICK_NS     625000
`define MED_GAP_NS      1250000
`define MED_FALL_NS     5000000
`define MED_SEC_NS      1000000000
`define MED_TICK_CYCLES (`MED_TICK_NS / `MED_CLK_NS)
`define MED_GAP_TICKS   (`MED_GAP_NS / `MED_TICK_NS)
`define MED_FALL_TICKS  (`MED_FALL_NS / `MED_TICK_NS)
`define MED_SEC_TICKS   (`MED_SEC_NS / `MED_TICK_NS)
`endif

// [hw/med_pkg.sv]
// types of the motion event block
package med_pkg;
  typedef enum logic [2:0] {
    TS_IDLE   = 3'h0,
    TS_FIRST  = 3'h1,
    TS_QUIET  = 3'h3,
    TS_WAIT2  = 3'h2,
    TS_SECOND = 3'h6,
    TS_LONG   = 3'h5
  } med_tap_t;

  typedef struct packed {
    logic [2:0]       sck_s;
    logic [2:0]       csn_s;
    logic [1:0]       mosi_s;
    logic [7:0]       sh;
    logic [2:0]       bitc;
    logic             cmd_done;
    logic             rd;
    logic             mb;
    logic [5:0]       addr;
    logic [7:0]       tx;
    logic             miso;
    logic [7:0]       tap_lvl;
    logic [7:0]       trim_x;
    logic [7:0]       trim_y;
    logic [7:0]       trim_z;
    logic [7:0]       width;
    logic [7:0]       gap;
    logic [7:0]       span;
    logic [7:0]       mot_lvl;
    logic [7:0]       still_lvl;
    logic [7:0]       still_time;
    logic [7:0]       coupling;
    logic [7:0]       fall_lvl;
    logic [7:0]       fall_time;
    logic [3:0]       tap_axes;
    logic [4:0]       speed;
    logic [5:0]       origin;
    logic [15:0]      tick_cnt;
    med_tap_t         tst;
    logic [15:0]      cnt;
    logic [2:0]       tap_hit;
    logic [2:0][15:0] aref;
    logic             aref_ok;
    logic [2:0][15:0] iref;
    logic             seen;
    logic             ibelow;
    logic [19:0]      icnt;
    logic             idone;
    logic             fbelow;
    logic [11:0]      fcnt;
    logic             fdone;
    logic             st_flag;
    logic             dt_flag;
    logic             act_flag;
    logic             inact_flag;
    logic             ff_flag;
  } med_state_t;
endpackage

// [hw/med_motion_detect.sv]
// motion event detection with its serial-reached configuration registers
// Function
// - tap level unsigned, 62.5 mg per count
// - signed axis trims, 15.6 mg per count
// - tap no longer than width; zero disables
// - quiet gap before second tap window
// - second tap must begin within span
// - zero gap or span disables double tap
// - activity compares magnitude to motion level
// - inactivity compares magnitude to stillness level
// - stillness must last stillness time seconds
// - inactivity uses filtered samples, needs one
// - zero stillness time flags immediately
// - axis enables; none disables the function
// - dc coupling compares acceleration directly
// - ac activity compares against captured reference
// - ac inactivity refreshes reference when exceeded
// - free fall uses root-sum-square versus level
// - free fall needs below level for time
// - tap axes upper bits zero, inhibit, enables
// - origin bits overwritten by events, never cleared
// - status bit 3 shows auto sleep
// - speed register low-power bit, rate 0x0a
// - event flags held until source read
`include "med_map.svh"
module med_motion_detect #(
  parameter int unsigned TICK_CYCLES = `MED_TICK_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        ce,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        mosi,
  output logic             miso,
  output logic             miso_oe,
  input  wire logic [15:0] accel_x,
  input  wire logic [15:0] accel_y,
  input  wire logic [15:0] accel_z,
  input  wire logic        raw_valid,
  input  wire logic        out_valid,
  input  wire logic        auto_sleep,
  input  wire logic        src_read,
  output logic             single_tap,
  output logic             double_tap,
  output logic             activity,
  output logic             inactivity,
  output logic             free_fall,
  output logic             low_power,
  output logic [3:0]       rate_code
);
  import med_pkg::*;

  med_state_t s;
  med_state_t n;
  logic [2:0][15:0] acc;
  logic [2:0][15:0] adj;

  // magnitude of a signed sample
  function automatic logic [15:0] mag(input logic [15:0] v);
    return v[15] ? 16'(-v) : v;
  endfunction

  // threshold in sample units: 62.5 mg is 16 sample counts
  function automatic logic [15:0] lvl16(input logic [7:0] t);
    return {4'h0, t, 4'h0};
  endfunction

  function automatic logic [31:0] sq(input logic [15:0] v);
    return mag(v) * mag(v);
  endfunction

  function automatic logic [7:0] rd_reg(input med_state_t r, input logic [5:0] a,
                                        input logic sl);
    case (a)
      `MED_A_ID:        return `MED_ID_VALUE;
      `MED_A_TAP_LVL:   return r.tap_lvl;
      `MED_A_TRIM_X:    return r.trim_x;
      `MED_A_TRIM_Y:    return r.trim_y;
      `MED_A_TRIM_Z:    return r.trim_z;
      `MED_A_TAP_WIDTH: return r.width;
      `MED_A_TAP_GAP:   return r.gap;
      `MED_A_TAP_SPAN:  return r.span;
      `MED_A_MOT_LVL:   return r.mot_lvl;
      `MED_A_STILL_LVL: return r.still_lvl;
      `MED_A_STILL_TIM: return r.still_time;
      `MED_A_COUPLING:  return r.coupling;
      `MED_A_FALL_LVL:  return r.fall_lvl;
      `MED_A_FALL_TIM:  return r.fall_time;
      `MED_A_TAP_AXES:  return {4'h0, r.tap_axes};
      `MED_A_ORIGIN:    return {1'b0, r.origin[5:3], sl, r.origin[2:0]};
      `MED_A_SPEED:     return {3'h0, r.speed};
      default:          return 8'h00;
    endcase
  endfunction

  assign acc[0] = accel_x;
  assign acc[1] = accel_y;
  assign acc[2] = accel_z;
  // trim of 15.6 mg is four sample counts
  assign adj[0] = acc[0] + {{6{s.trim_x[7]}}, s.trim_x, 2'b00};
  assign adj[1] = acc[1] + {{6{s.trim_y[7]}}, s.trim_y, 2'b00};
  assign adj[2] = acc[2] + {{6{s.trim_z[7]}}, s.trim_z, 2'b00};

  logic       tick;
  logic       tap_en;
  logic       dbl_en;
  logic       above;
  logic [2:0] hit;
  logic [2:0] ahit;
  logic       act_en;
  logic       inact_en;
  logic       below_now;
  logic [33:0] rss2;
  logic [31:0] fthr2;
  logic [7:0]  wbyte;
  logic        sck_rise;
  logic        sck_fall;

  always_comb begin
    n = s;
    wbyte = 8'h00;
    // synchronisers: stage 0 only feeds stage 1
    n.sck_s = {s.sck_s[1:0], sclk};
    n.csn_s = {s.csn_s[1:0], cs_n};
    n.mosi_s = {s.mosi_s[0], mosi};
    sck_rise = s.sck_s[1] & ~s.sck_s[2];
    sck_fall = ~s.sck_s[1] & s.sck_s[2];
    if (s.csn_s[1]) begin
      n.bitc = 3'h0;
      n.cmd_done = 1'b0;
    end else if (sck_rise) begin
      n.sh = {s.sh[6:0], s.mosi_s[1]};
      n.bitc = 3'(s.bitc + 3'h1);
      if (s.bitc == 3'h7) begin
        if (!s.cmd_done) begin
          n.cmd_done = 1'b1;
          n.rd = n.sh[7];
          n.mb = n.sh[6];
          n.addr = n.sh[5:0];
          n.tx = rd_reg(s, n.sh[5:0], auto_sleep);
        end else begin
          if (!s.rd) begin
            wbyte = n.sh;
            case (s.addr)
              `MED_A_TAP_LVL:   n.tap_lvl = wbyte;
              `MED_A_TRIM_X:    n.trim_x = wbyte;
              `MED_A_TRIM_Y:    n.trim_y = wbyte;
              `MED_A_TRIM_Z:    n.trim_z = wbyte;
              `MED_A_TAP_WIDTH: n.width = wbyte;
              `MED_A_TAP_GAP:   n.gap = wbyte;
              `MED_A_TAP_SPAN:  n.span = wbyte;
              `MED_A_MOT_LVL:   n.mot_lvl = wbyte;
              `MED_A_STILL_LVL: n.still_lvl = wbyte;
              `MED_A_STILL_TIM: n.still_time = wbyte;
              `MED_A_COUPLING:  n.coupling = wbyte;
              `MED_A_FALL_LVL:  n.fall_lvl = wbyte;
              `MED_A_FALL_TIM:  n.fall_time = wbyte;
              `MED_A_TAP_AXES:  n.tap_axes = wbyte[3:0];
              `MED_A_SPEED:     n.speed = wbyte[4:0];
              default:          n.speed = s.speed;
            endcase
          end
          if (s.mb) begin
            n.addr = 6'(s.addr + 6'h1);
          end
          n.tx = rd_reg(s, n.addr, auto_sleep);
        end
      end
    end else if (sck_fall) begin
      n.miso = s.tx[7];
      n.tx = {s.tx[6:0], 1'b0};
    end

    // source read clears first, so a set later in this pass wins
    if (src_read) begin
      n.st_flag = 1'b0;
      n.dt_flag = 1'b0;
      n.act_flag = 1'b0;
      n.inact_flag = 1'b0;
      n.ff_flag = 1'b0;
    end

    // one timebase for every qualifier
    tick = (s.tick_cnt == 16'(TICK_CYCLES - 1));
    n.tick_cnt = tick ? 16'h0 : 16'(s.tick_cnt + 16'h1);

    // tap
    for (int i = 0; i < 3; i++) begin
      hit[i] = s.tap_axes[2 - i] && (mag(adj[i]) > lvl16(s.tap_lvl));
    end
    above = |hit;
    tap_en = (s.width != 8'h00) && (|s.tap_axes[2:0]);
    dbl_en = (s.gap != 8'h00) && (s.span != 8'h00);
    case (s.tst)
      TS_IDLE: begin
        if (tap_en && above) begin
          n.tst = TS_FIRST;
          n.cnt = 16'h0;
          n.tap_hit = hit;
        end
      end
      TS_FIRST: begin
        if (tick) begin
          n.cnt = 16'(s.cnt + 16'h1);
        end
        if (!tap_en) begin
          n.tst = TS_IDLE;
        end else if (n.cnt > {8'h00, s.width}) begin
          n.tst = TS_LONG;
        end else if (!above) begin
          n.st_flag = 1'b1;
          n.origin[2:0] = {s.tap_hit[0], s.tap_hit[1], s.tap_hit[2]};
          n.cnt = 16'h0;
          n.tst = dbl_en ? TS_QUIET : TS_IDLE;
        end
      end
      TS_QUIET: begin
        if (tick) begin
          n.cnt = 16'(s.cnt + 16'h1);
        end
        if (!dbl_en || !tap_en) begin
          n.tst = TS_IDLE;
        end else if (above && s.tap_axes[`MED_B_INHIBIT]) begin
          n.tst = TS_IDLE;
        end else if (n.cnt == 16'(s.gap * `MED_GAP_TICKS)) begin
          n.tst = TS_WAIT2;
          n.cnt = 16'h0;
        end
      end
      TS_WAIT2: begin
        if (tick) begin
          n.cnt = 16'(s.cnt + 16'h1);
        end
        if (!dbl_en || !tap_en) begin
          n.tst = TS_IDLE;
        end else if (above) begin
          n.tst = TS_SECOND;
          n.cnt = 16'h0;
        end else if (n.cnt == 16'(s.span * `MED_GAP_TICKS)) begin
          n.tst = TS_IDLE;
        end
      end
      TS_SECOND: begin
        if (tick) begin
          n.cnt = 16'(s.cnt + 16'h1);
        end
        if (!dbl_en || !tap_en) begin
          n.tst = TS_IDLE;
        end else if (n.cnt > {8'h00, s.width}) begin
          n.tst = TS_LONG;
        end else if (!above) begin
          n.dt_flag = 1'b1;
          n.tst = TS_IDLE;
        end
      end
      // too long for a tap: rearm only once the level drops
      TS_LONG: begin
        if (!tap_en || !above) begin
          n.tst = TS_IDLE;
        end
      end
      default: n.tst = TS_IDLE;
    endcase

    // activity on raw samples
    act_en = |s.coupling[6:4];
    for (int i = 0; i < 3; i++) begin
      ahit[i] = s.coupling[6 - i] && (mag(16'(adj[i] -
                (s.coupling[`MED_B_ACT_AC] ? s.aref[i] : 16'h0)))
                > lvl16(s.mot_lvl));
    end
    if (!act_en) begin
      n.aref_ok = 1'b0;
    end else if (raw_valid) begin
      if (s.coupling[`MED_B_ACT_AC] && !s.aref_ok) begin
        n.aref = adj;
        n.aref_ok = 1'b1;
      end else if (|ahit) begin
        n.act_flag = 1'b1;
        n.origin[5:3] = {ahit[0], ahit[1], ahit[2]};
        n.aref_ok = 1'b0;
      end
    end

    // inactivity on filtered samples
    inact_en = |s.coupling[2:0];
    below_now = 1'b1;
    for (int i = 0; i < 3; i++) begin
      if (s.coupling[2 - i] && (mag(16'(adj[i] -
          (s.coupling[`MED_B_INACT_AC] ? s.iref[i] : 16'h0)))
          >= lvl16(s.still_lvl))) begin
        below_now = 1'b0;
      end
    end
    if (!inact_en) begin
      n.seen = 1'b0;
      n.ibelow = 1'b0;
      n.icnt = 20'h0;
      n.idone = 1'b0;
    end else if (out_valid) begin
      n.seen = 1'b1;
      n.ibelow = below_now;
      if (!below_now) begin
        n.icnt = 20'h0;
        n.idone = 1'b0;
        if (s.coupling[`MED_B_INACT_AC]) begin
          n.iref = adj;
        end
      end else if (s.still_time == 8'h00 && !s.idone) begin
        n.inact_flag = 1'b1;
        n.idone = 1'b1;
      end
    end
    // ticks on sample cycles count too, or the time would stretch
    if (tick && s.seen && s.ibelow && n.ibelow && !s.idone && s.still_time != 8'h00) begin
      n.icnt = 20'(n.icnt + 20'h1);
      if (n.icnt >= 20'(s.still_time * `MED_SEC_TICKS)) begin
        n.inact_flag = 1'b1;
        n.idone = 1'b1;
      end
    end

    // free fall: squares avoid a root
    rss2 = {2'b00, sq(adj[0])} + {2'b00, sq(adj[1])} + {2'b00, sq(adj[2])};
    fthr2 = sq(lvl16(s.fall_lvl));
    if (raw_valid) begin
      n.fbelow = rss2 < {2'b00, fthr2};
      if (!n.fbelow) begin
        n.fcnt = 12'h0;
        n.fdone = 1'b0;
      end
    end
    if (tick && s.fbelow && n.fbelow && !s.fdone) begin
      n.fcnt = 12'(s.fcnt + 12'h1);
      if (n.fcnt >= 12'(s.fall_time * `MED_FALL_TICKS)) begin
        n.ff_flag = 1'b1;
        n.fdone = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      s <= '0;
      s.sck_s <= 3'h7;
      s.csn_s <= 3'h7;
      s.speed <= `MED_SPEED_RST;
      s.tst <= TS_IDLE;
    end else if (ce) begin
      s <= n;
    end
  end

  assign miso = s.miso;
  assign miso_oe = ~s.csn_s[1];
  assign single_tap = s.st_flag;
  assign double_tap = s.dt_flag;
  assign activity = s.act_flag;
  assign inactivity = s.inact_flag;
  assign free_fall = s.ff_flag;
  assign low_power = s.speed[`MED_B_LOWPWR];
  assign rate_code = s.speed[3:0];

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  chk_speed_reset: assert property ($rose(reset_n) |-> s.speed == 5'h0a)
    else $error("speed register not at reset value");
  chk_flag_hold: assert property (s.ff_flag && !src_read |=> s.ff_flag)
    else $error("free fall flag dropped without source read");
  chk_fall_time: assert property ($rose(s.ff_flag) |->
      $past(s.fcnt) + 12'h1 >= {1'b0, s.fall_time, 3'h0})
    else $error("free fall flagged before fall time");
  chk_width_zero: assert property (s.width == 8'h00 && ce |=> s.tst == TS_IDLE)
    else $error("tap machine left idle with zero width");
  chk_width_max: assert property (s.tst == TS_FIRST |-> s.cnt <= {8'h00, s.width})
    else $error("tap held longer than width");
  chk_double_gate: assert property ((s.gap == 8'h00 || s.span == 8'h00) && ce |=>
      !(s.tst inside {TS_QUIET, TS_WAIT2, TS_SECOND}))
    else $error("double tap armed while disabled");
  chk_quiet_gap: assert property (s.tst == TS_QUIET ##1 s.tst == TS_WAIT2 |->
      $past(s.cnt) + 16'h1 == {7'h00, s.gap, 1'b0})
    else $error("quiet gap length wrong");
  chk_still_zero: assert property (ce && out_valid && |s.coupling[2:0] && below_now
      && s.still_time == 8'h00 && !s.idone |=> s.inact_flag)
    else $error("zero stillness time did not flag");
  chk_origin_mask: assert property ($rose(s.act_flag) && $stable(s.coupling) |->
      (s.origin[5:3] & ~s.coupling[6:4]) == 3'h0)
    else $error("origin shows a disabled axis");
endmodule

// [bench/med_host_model.sv]
// host-side serial master model for the motion event block
module med_host_model (
  input  wire logic mclk,
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // one frame: command byte, then one data byte; mode 3, msb first, 8 mclk per bit
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wdat, output logic [7:0] rdat);
    logic [15:0] sh;
    sh = {cmd, wdat};
    rdat = 8'h00;
    @(posedge mclk);
    cs_n <= 1'b0;
    repeat (4) @(posedge mclk);
    for (int i = 15; i >= 0; i--) begin
      sclk <= 1'b0;
      mosi <= sh[i];
      repeat (4) @(posedge mclk);
      sclk <= 1'b1;
      rdat = {rdat[6:0], miso};
      repeat (4) @(posedge mclk);
    end
    // hold select past the commit so the synchronised write lands
    cs_n <= 1'b1;
    // released line has no pull: show the inverse, not the last bit
    mosi <= ~sh[0];
    repeat (8) @(posedge mclk);
  endtask
endmodule

// [bench/testbench.sv]
// self-checking bench of the motion event block
`include "med_map.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 4;
  logic        mclk, reset_n, sclk, cs_n, mosi, miso, miso_oe;
  logic [15:0] accel_x, accel_y, accel_z;
  logic        raw_valid, out_valid, auto_sleep, src_read;
  logic        single_tap, double_tap, activity, inactivity, free_fall, low_power;
  logic [3:0]  rate_code;
  logic [2:0]  ph = 3'h0;
  logic [7:0]  rd;
  int          n_mismatch = 0;
  int          tests_run = 0;

  med_motion_detect #(.TICK_CYCLES(TK)) i_dut (
    .mclk(mclk), .reset_n(reset_n), .ce(1'b1), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .miso(miso), .miso_oe(miso_oe), .accel_x(accel_x), .accel_y(accel_y), .accel_z(accel_z),
    .raw_valid(raw_valid), .out_valid(out_valid), .auto_sleep(auto_sleep),
    .src_read(src_read), .single_tap(single_tap), .double_tap(double_tap),
    .activity(activity), .inactivity(inactivity), .free_fall(free_fall),
    .low_power(low_power), .rate_code(rate_code));
  med_host_model i_host (.mclk(mclk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));

  initial mclk = 1'b0;
  always #10 mclk = ~mclk;
  // raw samples every 4 cycles, filtered every 8
  always @(posedge mclk) begin
    ph <= ph + 3'h1;
    raw_valid <= (ph[1:0] == 2'h0);
    out_valid <= (ph == 3'h0);
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] x;
    i_host.xfer({2'b00, a}, d, x);
  endtask
  task automatic rdreg(input logic [5:0] a, output logic [7:0] d);
    i_host.xfer({2'b10, a}, 8'h00, d);
  endtask
  // bounded wait; flags rising before lo cycles count as early
  task automatic expect_rise(input string what, ref logic f, input int lo, input int hi);
    int k;
    k = 0;
    while (f !== 1'b1 && k < hi) begin
      @(posedge mclk);
      k++;
    end
    check(what, {7'h0, f}, 8'h01);
    check({what, " early"}, {7'h0, k < lo}, 8'h00);
  endtask
  task automatic clr;
    @(posedge mclk);
    src_read <= 1'b1;
    @(posedge mclk);
    src_read <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
  task automatic tap(input int n);
    accel_x <= 16'd40;
    repeat (n) @(posedge mclk);
    accel_x <= 16'd0;
  endtask
  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge mclk);
    n_mismatch++;
    $display("unexpected hang: watchdog expired");
    print_verdict();
  end

  initial begin
    reset_n = 1'b0;
    {accel_x, accel_y} = 32'h0;
    accel_z = 16'h0;
    {auto_sleep, src_read} = 2'h0;
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    check("rate_code", {4'h0, rate_code}, 8'h0a);
    check("low_power", {7'h0, low_power}, 8'h00);
    check("miso_oe idle", {7'h0, miso_oe}, 8'h00);
    rdreg(`MED_A_SPEED, rd);
    check("speed", rd, {3'h0, `MED_SPEED_RST});
    rdreg(`MED_A_ID, rd);
    check("ident", rd, `MED_ID_VALUE);
    rdreg(6'h10, rd);
    check("unmapped", rd, 8'h00);
    wr(`MED_A_ORIGIN, 8'hff);
    rdreg(`MED_A_ORIGIN, rd);
    check("origin awake", rd, 8'h00);
    auto_sleep <= 1'b1;
    rdreg(`MED_A_ORIGIN, rd);
    check("origin sleep", rd, 8'h08);
    for (int a = 'h1d; a <= 'h2c; a++) begin
      if (a == 'h2b) continue;
      wr(a[5:0], 8'ha5 ^ a[7:0]);
      rdreg(a[5:0], rd);
      check("reg rw", rd, (8'ha5 ^ a[7:0]) & (a == 'h2a ? 8'h0f : a == 'h2c ? 8'h1f : 8'hff));
      wr(a[5:0], 8'h00);
    end
    wr(`MED_A_SPEED, 8'h1a);
    check("rate/lp", {3'h0, low_power, rate_code}, 8'h1a);
    clr();
    check("flags clear", {3'h0, single_tap, double_tap, activity, inactivity, free_fall}, 8'h00);
    // free fall: still sensor, recommended settings, 20 x 8 ticks
    wr(`MED_A_FALL_TIM, 8'h14);
    wr(`MED_A_FALL_LVL, 8'h05);
    expect_rise("free_fall", free_fall, 600, 680);
    repeat (50) @(posedge mclk);
    check("ff held", {7'h0, free_fall}, 8'h01);
    accel_z <= 16'd256;
    clr();
    check("ff cleared", {7'h0, free_fall}, 8'h00);
    // activity: excluded axes first, then dc on x, then ac boundary
    wr(`MED_A_MOT_LVL, 8'h02);
    accel_x <= 16'd200;
    repeat (40) @(posedge mclk);
    check("act none", {7'h0, activity}, 8'h00);
    wr(`MED_A_COUPLING, 8'h40);
    expect_rise("act dc", activity, 0, 40);
    rdreg(`MED_A_ORIGIN, rd);
    check("origin act", rd, 8'h48);
    clr();
    wr(`MED_A_COUPLING, 8'hc0);
    clr();
    accel_x <= 16'd232;
    repeat (40) @(posedge mclk);
    check("act ac 32", {7'h0, activity}, 8'h00);
    accel_x <= 16'd233;
    expect_rise("act ac 33", activity, 0, 20);
    wr(`MED_A_COUPLING, 8'h04);
    clr();
    // inactivity on filtered samples, time zero then one second
    wr(`MED_A_STILL_LVL, 8'h01);
    repeat (40) @(posedge mclk);
    check("inact above", {7'h0, inactivity}, 8'h00);
    accel_x <= 16'd15;
    expect_rise("inact t0", inactivity, 0, 20);
    accel_x <= 16'd100;
    repeat (20) @(posedge mclk);
    wr(`MED_A_STILL_TIM, 8'h01);
    clr();
    accel_x <= 16'd0;
    expect_rise("inact t1", inactivity, 6360, 6440);
    wr(`MED_A_COUPLING, 8'h00);
    // taps on x: width 3 ticks, double tap off while gap is zero
    wr(`MED_A_TAP_LVL, 8'h02);
    wr(`MED_A_TAP_WIDTH, 8'h03);
    wr(`MED_A_TAP_AXES, 8'h04);
    clr();
    tap(8);
    expect_rise("single", single_tap, 0, 20);
    repeat (60) @(posedge mclk);
    check("no double", {7'h0, double_tap}, 8'h00);
    rdreg(`MED_A_ORIGIN, rd);
    check("origin tap", rd, 8'h4c);
    clr();
    tap(40);
    repeat (40) @(posedge mclk);
    check("long tap", {7'h0, single_tap}, 8'h00);
    wr(`MED_A_TAP_GAP, 8'h01);
    wr(`MED_A_TAP_SPAN, 8'h04);
    clr();
    tap(8);
    repeat (20) @(posedge mclk);
    tap(8);
    expect_rise("double", double_tap, 0, 30);
    // trim of -2 counts pulls a 40 sample down to the level, no tap
    wr(`MED_A_TRIM_X, 8'hfe);
    clr();
    tap(8);
    repeat (40) @(posedge mclk);
    check("trimmed tap", {7'h0, single_tap}, 8'h00);
    print_verdict();
  end
endmodule
